// ---- design/anm_monitor.sv ----
// Negotiation arbitration, parallel detection, remote fault and progress monitor
// Assumes line sense pins are asynchronous levels; APB master on pclk
`timescale 1ns/1ps
module anm_monitor
   import anm_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Line sense from receive side
   input  wire anm_sense_t  line_sense,
   input  wire logic [15:0] partner_word,
   // Technology control
   output logic             flp_tx_en,
   output logic             tech_100_en,
   output logic             tech_10_en,
   output logic             full_duplex,
   output logic             tx_remote_fault
);

   // ==========================================================
   // Declarations
   anm_sense_t  sense_m_q;
   anm_sense_t  sense_s_q;
   logic [15:0] word_m_q;
   logic [15:0] word_s_q;
   logic        page_prev_q;
   logic        page_evt;
   anm_state_t  st_q;
   logic        an_en_q;
   logic        an_en_prev_q;
   logic [15:0] adv_q;
   logic [15:0] lpa_q;
   logic        lp_cap_q;
   logic        pd_fault_q;
   logic        rf_q;
   logic        done_q;
   logic        done_prev_q;
   logic        rate_q;
   logic        dpx_q;
   logic        pd_100_q;
   logic        no_sig_q;
   logic        srst_q;
   logic [3:0]  prog_q;
   logic        acc;
   logic        fin;
   logic        wr_fin;
   logic        rd_dsr;
   logic        rd_exp;
   logic [4:0]  idx;
   logic        mapped;
   logic [31:0] rd_mux;
   logic        restart;
   logic        srst_w;
   logic        link_fail;
   logic        done_evt;
   logic        negotiating;
   anm_res_t    res;

   // ==========================================================
   // Line sense synchronisers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sense_m_q <= '0;
         sense_s_q <= '0;
         word_m_q  <= 16'h0000;
         word_s_q  <= 16'h0000;
      end else begin
         sense_m_q <= line_sense;
         sense_s_q <= sense_m_q;
         word_m_q  <= partner_word;
         word_s_q  <= word_m_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         page_prev_q <= 1'b0;
      end else begin
         page_prev_q <= sense_s_q.page_valid;
      end
   end

   assign page_evt = sense_s_q.page_valid & ~page_prev_q;

   // ==========================================================
   // APB handshake, one wait state
   assign acc    = psel & penable;
   assign fin    = acc & pready;
   assign idx    = paddr[6:2];
   assign mapped = (paddr[7] == 1'b0) && (paddr[1:0] == 2'b00) &&
                   (idx == IDX_CTRL || idx == IDX_STAT || idx == IDX_ADV ||
                    idx == IDX_LPA  || idx == IDX_EXP  || idx == IDX_DSR ||
                    idx == IDX_RFR);
   assign wr_fin = fin & pwrite & mapped;
   // R24: completed read only
   assign rd_dsr = fin & ~pwrite & mapped & (idx == IDX_DSR);
   assign rd_exp = fin & ~pwrite & mapped & (idx == IDX_EXP);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (acc & ~pready) begin
         pready  <= 1'b1;
         pslverr <= ~mapped;
         // R19: data taken before latch update
         prdata  <= (mapped & ~pwrite) ? rd_mux : 32'h0000_0000;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // ==========================================================
   // Read multiplexer
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (idx)
         IDX_CTRL: begin
            rd_mux[CTRL_AN_EN] = an_en_q;
         end
         IDX_STAT: begin
            // R3: complete bit
            rd_mux[STAT_DONE]    = done_q;
            rd_mux[STAT_RF]      = rf_q;
            rd_mux[STAT_AN_ABLE] = 1'b1;
            rd_mux[STAT_LINK]    = sense_s_q.link_ok;
         end
         IDX_ADV: begin
            rd_mux[15:0] = adv_q;
         end
         IDX_LPA: begin
            rd_mux[15:0] = lpa_q;
         end
         IDX_EXP: begin
            rd_mux[EXP_PDF]    = pd_fault_q;
            rd_mux[EXP_LP_CAP] = lp_cap_q;
         end
         IDX_DSR: begin
            // R22: rate, duplex, link
            rd_mux[DSR_RATE] = rate_q;
            rd_mux[DSR_DPX]  = dpx_q;
            // R15: code split over two fields
            rd_mux[DSR_PROG_LSB +: 3] = prog_q[2:0];
            rd_mux[DSR_DONE]  = prog_q[3];
            rd_mux[DSR_NOSIG] = no_sig_q;
            rd_mux[DSR_RF]    = rf_q;
            rd_mux[DSR_LINK]  = sense_s_q.link_ok;
         end
         IDX_RFR: begin
            rd_mux[RFR_RF] = rf_q;
         end
         default: begin
            rd_mux = 32'h0000_0000;
         end
      endcase
   end

   // ==========================================================
   // Control register and restart sources
   assign srst_w = wr_fin & (idx == IDX_CTRL) & pwdata[CTRL_SRST];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         srst_q <= 1'b0;
      end else begin
         srst_q <= srst_w;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         an_en_q      <= AN_EN_RST;
         an_en_prev_q <= AN_EN_RST;
      end else if (srst_q) begin
         an_en_q      <= AN_EN_RST;
         an_en_prev_q <= AN_EN_RST;
      end else begin
         if (wr_fin && idx == IDX_CTRL) begin
            an_en_q <= pwdata[CTRL_AN_EN];
         end
         an_en_prev_q <= an_en_q;
      end
   end

   assign link_fail = (st_q == AN_COMPLETE) & ~sense_s_q.link_ok;
   // R14: three restart causes
   assign restart = (wr_fin & (idx == IDX_CTRL) & pwdata[CTRL_RESTART]) |
                    (an_en_q & ~an_en_prev_q) | link_fail;

   // ==========================================================
   // Arbitration state machine
   assign negotiating = (st_q == AN_ABILITY) || (st_q == AN_ACK);
   assign res         = anm_resolve(adv_q & lpa_q);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= AN_IDLE;
      // R11: reset idles arbitration
      end else if (srst_q) begin
         st_q <= AN_IDLE;
      // R12: restart idles arbitration
      end else if (restart || !an_en_q) begin
         st_q <= AN_IDLE;
      end else begin
         case (st_q)
            AN_IDLE: begin
               st_q <= AN_ABILITY;
            end
            AN_ABILITY: begin
               if (sense_s_q.flp) begin
                  st_q <= AN_ACK;
               // R8: mixed indications
               end else if (sense_s_q.nlp && sense_s_q.idle100) begin
                  st_q <= AN_PD_FAULT;
               // R5: classify legacy partner
               end else if (sense_s_q.nlp) begin
                  st_q <= AN_NLP;
               end else if (sense_s_q.idle100) begin
                  st_q <= AN_IDLE100;
               end
            end
            AN_ACK: begin
               if (page_evt) begin
                  st_q <= AN_CACK;
               end
            end
            AN_CACK: begin
               st_q <= res.ok ? AN_COMPLETE : AN_ABILITY;
            end
            AN_NLP, AN_IDLE100: begin
               st_q <= AN_LINK_WAIT;
            end
            AN_LINK_WAIT: begin
               if (sense_s_q.link_ok) begin
                  st_q <= AN_COMPLETE;
               end
            end
            AN_PD_FAULT: begin
               st_q <= AN_PD_FAULT;
            end
            AN_COMPLETE: begin
               st_q <= AN_COMPLETE;
            end
            default: begin
               st_q <= AN_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Partner ability and expansion bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lpa_q    <= 16'h0000;
         lp_cap_q <= 1'b0;
      end else if (srst_q || st_q == AN_IDLE) begin
         lpa_q    <= 16'h0000;
         lp_cap_q <= 1'b0;
      end else if (st_q == AN_ACK && page_evt) begin
         lpa_q    <= word_s_q;
         // R6: partner negotiates
         lp_cap_q <= 1'b1;
      end else if (st_q == AN_NLP) begin
         // R1: partner cannot negotiate
         lp_cap_q        <= 1'b0;
         // R2: 10T half detected
         lpa_q[AB_10_HD] <= 1'b1;
      end else if (st_q == AN_IDLE100) begin
         lp_cap_q        <= 1'b0;
         lpa_q[AB_TX_HD] <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pd_fault_q <= 1'b0;
      end else if (srst_q) begin
         pd_fault_q <= 1'b0;
      // R8: set wins over read clear
      end else if (st_q == AN_ABILITY && sense_s_q.nlp && sense_s_q.idle100 &&
                   !sense_s_q.flp) begin
         pd_fault_q <= 1'b1;
      end else if (rd_exp) begin
         pd_fault_q <= 1'b0;
      end
   end

   // ==========================================================
   // Remote fault copies and advertisement
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rf_q <= 1'b0;
      end else if (srst_q) begin
         rf_q <= 1'b0;
      // R9: one flop, three copies; LPA copy from lpa_q
      end else if (st_q == AN_ACK && page_evt && word_s_q[AB_RF]) begin
         rf_q <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adv_q <= ADV_RST;
      end else if (srst_q) begin
         adv_q <= ADV_RST;
      end else begin
         if (wr_fin && idx == IDX_ADV) begin
            adv_q <= (pwdata[15:0] & ADV_WMSK) | (ADV_RST & ~ADV_WMSK);
         end
         // R10: local fault advertised, set wins
         if (sense_s_q.local_fault) begin
            adv_q[AB_RF] <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Resolution and status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pd_100_q <= 1'b0;
      end else if (st_q == AN_NLP) begin
         pd_100_q <= 1'b0;
      end else if (st_q == AN_IDLE100) begin
         pd_100_q <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rate_q <= 1'b0;
         dpx_q  <= 1'b0;
      end else if (srst_q) begin
         rate_q <= 1'b0;
         dpx_q  <= 1'b0;
      // R23: negotiated choice
      end else if (st_q == AN_CACK && res.ok) begin
         rate_q <= res.r100;
         dpx_q  <= res.fdx;
      end else if (st_q == AN_LINK_WAIT) begin
         rate_q <= pd_100_q;
         dpx_q  <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_q      <= 1'b0;
         done_prev_q <= 1'b0;
         no_sig_q    <= 1'b0;
      end else begin
         // R3: complete while linked
         done_q      <= (st_q == AN_COMPLETE) & ~srst_q;
         done_prev_q <= done_q;
         // R7: no signal seen
         no_sig_q    <= negotiating & ~sense_s_q.energy & ~srst_q;
      end
   end

   assign done_evt = done_q & ~done_prev_q;

   // ==========================================================
   // Progress monitor
   // R11: reset clears latch; R12: restart leaves it
   anm_progress_latch u_prog (
      .pclk     (pclk),
      .presetn  (presetn),
      .clear    (srst_q),
      // R13: after done only reads move it
      .rd_evt   (rd_dsr),
      // R20: completion latches all ones
      .done_evt (done_evt),
      // R21: complete reads as 8h afterward
      .cur_code (anm_code(st_q)),
      .code_q   (prog_q)
   );

   // ==========================================================
   // Technology enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flp_tx_en       <= 1'b0;
         tech_100_en     <= 1'b0;
         tech_10_en      <= 1'b0;
         full_duplex     <= 1'b0;
         tx_remote_fault <= 1'b0;
      end else begin
         flp_tx_en       <= negotiating | (st_q == AN_CACK);
         // R4: one technology enabled
         tech_100_en     <= (st_q == AN_COMPLETE) & rate_q;
         tech_10_en      <= (st_q == AN_COMPLETE) & ~rate_q;
         full_duplex     <= (st_q == AN_COMPLETE) & dpx_q;
         tx_remote_fault <= adv_q[AB_RF];
      end
   end

endmodule : anm_monitor

// ---- design/anm_pkg.sv ----
// Constants, types and helpers of the negotiation progress monitor block
// Assumes an APB master with 32-bit data; register byte address is four times its index
// How it works
// R1: Unanswered fast pulse bursts start parallel detection and clear partner_negotiation_capable.
// R2: Parallel detection sets partner ability bit 5 for 10T half, 7 for 100TX half.
// R3: Successful parallel detection sets the negotiation complete status bit.
// R4: The detected technology is enabled, every unused technology disabled.
// R5: Normal link pulses only mean 10T; scrambled idles mean non-negotiating 100TX.
// R6: Partner answering bursts with bursts sets partner_negotiation_capable.
// R7: No receive signal during negotiation sets the detailed status no-signal bit.
// R8: Several technology indications at once set the parallel detection fault bit.
// R9: Partner remote fault sets all four remote fault copies.
// R10: A local link fault sets the advertised remote fault bit sent to the partner.
// R11: Any reset idles arbitration and monitor and zeroes the progress bits.
// R12: Restart idles arbitration but keeps progress bits until read, reset or progress.
// R13: After completion only a detailed status read or reset alters progress bits.
// R14: Restart on link failure, restart bit write, or enable toggled one-zero-one.
// R15: Progress code is complete bit 4 above detailed status bits 13 to 11.
// R16: Progress codes are only 0h to 8h and Fh.
// R17: Without reads the latch loads the arbitration code only when it is larger.
// R18: Every detailed status read loads the present arbitration code unless a reset or completion event falls in the same cycle.
// R19: A read returns the value latched before it; two reads give history, present.
// R20: First read after completion returns complete one and progress bits 111.
// R21: Later reads return complete one and progress bits 000 while the link holds.
// R22: Detailed status shows data rate bit 15, duplex bit 14, link bit 0.
// R23: Negotiated choice is 100TX full, T4, 100TX half, 10T full, 10T half; a common T4 here gives no choice and negotiation returns to ability.
// R24: A completed bus read of detailed status is the single progress read event.
package anm_pkg;

   // ==========================================================
   // Register indices, byte address is index times four
   localparam logic [4:0]  IDX_CTRL = 5'h0_0;
   localparam logic [4:0]  IDX_STAT = 5'h0_1;
   localparam logic [4:0]  IDX_ADV  = 5'h0_4;
   localparam logic [4:0]  IDX_LPA  = 5'h0_5;
   localparam logic [4:0]  IDX_EXP  = 5'h0_6;
   localparam logic [4:0]  IDX_DSR  = 5'h1_1;
   localparam logic [4:0]  IDX_RFR  = 5'h1_3;

   // ==========================================================
   // Field positions
   localparam int CTRL_SRST    = 15;
   localparam int CTRL_AN_EN   = 12;
   localparam int CTRL_RESTART = 9;
   localparam int STAT_DONE    = 5;
   localparam int STAT_RF      = 4;
   localparam int STAT_AN_ABLE = 3;
   localparam int STAT_LINK    = 2;
   localparam int AB_RF        = 13;
   localparam int AB_T4        = 9;
   localparam int AB_TX_FD     = 8;
   localparam int AB_TX_HD     = 7;
   localparam int AB_10_FD     = 6;
   localparam int AB_10_HD     = 5;
   localparam int EXP_PDF      = 4;
   localparam int EXP_LP_CAP   = 0;
   localparam int DSR_RATE     = 15;
   localparam int DSR_DPX      = 14;
   localparam int DSR_PROG_LSB = 11;
   localparam int DSR_DONE     = 4;
   localparam int DSR_NOSIG    = 3;
   localparam int DSR_RF       = 1;
   localparam int DSR_LINK     = 0;
   localparam int RFR_RF       = 13;

   // ==========================================================
   // Reset values and write masks
   localparam logic [15:0] ADV_RST  = 16'h01E1;
   localparam logic [15:0] ADV_WMSK = 16'h21E0;
   localparam logic        AN_EN_RST = 1'b1;

   // ==========================================================
   // Progress codes
   localparam logic [3:0] CODE_IDLE  = 4'h0;
   localparam logic [3:0] CODE_ABIL  = 4'h1;
   localparam logic [3:0] CODE_ACK   = 4'h2;
   localparam logic [3:0] CODE_CACK  = 4'h3;
   localparam logic [3:0] CODE_NLP   = 4'h4;
   localparam logic [3:0] CODE_IDL   = 4'h5;
   localparam logic [3:0] CODE_LWAIT = 4'h6;
   localparam logic [3:0] CODE_PDF   = 4'h7;
   localparam logic [3:0] CODE_LINK  = 4'h8;
   localparam logic [3:0] CODE_DONE  = 4'hF;

   // ==========================================================
   // Types
   typedef enum logic [3:0] {
      AN_IDLE, AN_ABILITY, AN_ACK, AN_CACK, AN_NLP, AN_IDLE100,
      AN_LINK_WAIT, AN_PD_FAULT, AN_COMPLETE
   } anm_state_t;

   typedef struct packed {
      logic flp;
      logic nlp;
      logic idle100;
      logic energy;
      logic link_ok;
      logic local_fault;
      logic page_valid;
   } anm_sense_t;

   typedef struct packed {
      logic ok;
      logic r100;
      logic fdx;
   } anm_res_t;

   // ==========================================================
   // Helpers
   // R23: priority pick
   function automatic anm_res_t anm_resolve(input logic [15:0] common);
      anm_res_t r;
      r = '{ok: 1'b0, r100: 1'b0, fdx: 1'b0};
      if (common[AB_TX_FD]) begin
         r = '{ok: 1'b1, r100: 1'b1, fdx: 1'b1};
      end else if (common[AB_T4]) begin
         r = '{ok: 1'b0, r100: 1'b0, fdx: 1'b0};
      end else if (common[AB_TX_HD]) begin
         r = '{ok: 1'b1, r100: 1'b1, fdx: 1'b0};
      end else if (common[AB_10_FD]) begin
         r = '{ok: 1'b1, r100: 1'b0, fdx: 1'b1};
      end else if (common[AB_10_HD]) begin
         r = '{ok: 1'b1, r100: 1'b0, fdx: 1'b0};
      end
      return r;
   endfunction : anm_resolve

   // R16: nine codes only
   function automatic logic [3:0] anm_code(input anm_state_t s);
      logic [3:0] c;
      c = CODE_IDLE;
      case (s)
         AN_IDLE:      c = CODE_IDLE;
         AN_ABILITY:   c = CODE_ABIL;
         AN_ACK:       c = CODE_ACK;
         AN_CACK:      c = CODE_CACK;
         AN_NLP:       c = CODE_NLP;
         AN_IDLE100:   c = CODE_IDL;
         AN_LINK_WAIT: c = CODE_LWAIT;
         AN_PD_FAULT:  c = CODE_PDF;
         AN_COMPLETE:  c = CODE_LINK;
         default:      c = CODE_IDLE;
      endcase
      return c;
   endfunction : anm_code

endpackage : anm_pkg

// ---- design/anm_progress_latch.sv ----
// Progress latch holding the highest arbitration code reached since the last read, or Fh on completion
// Assumes read and completion events are one-cycle pulses on the same clock
`timescale 1ns/1ps
module anm_progress_latch
   import anm_pkg::*;
(
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       clear,
   // Events
   input  wire logic       rd_evt,
   input  wire logic       done_evt,
   input  wire logic [3:0] cur_code,
   // Latched code
   output logic      [3:0] code_q
);

   // ==========================================================
   // Latch update
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_q <= CODE_IDLE;
      // R11: reset zeroes bits
      end else if (clear) begin
         code_q <= CODE_IDLE;
      // R20: completion shows all ones
      end else if (done_evt) begin
         code_q <= CODE_DONE;
      // R18: read loads present code
      end else if (rd_evt) begin
         code_q <= cur_code;
      // R17: only higher codes
      end else if (cur_code > code_q) begin
         code_q <= cur_code;
      end
   end

endmodule : anm_progress_latch

// ---- tb/anm_monitor_properties.sv ----
// Port checker of the negotiation monitor
// Assumes bind into anm_monitor, one pclk domain
`timescale 1ns/1ps
module anm_monitor_properties
   import anm_pkg::*;
(
   // Bus
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Line and technology
   input wire anm_sense_t  line_sense,
   input wire logic        flp_tx_en,
   input wire logic        tech_100_en,
   input wire logic        tech_10_en,
   input wire logic        tx_remote_fault
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ====================
   // Properties
   property p_ans;
      psel && penable && !pready |=> pready ##1 !pready;
   endproperty
   a_ans: assert property (p_ans) else $error("bus answer late");
   property p_err;
      pslverr |-> pready;
   endproperty
   a_err: assert property (p_err) else $error("lone error");
   property p_unm;
      psel && penable && !pready && paddr == 8'h08 |=> pslverr && prdata == 32'h0000_0000;
   endproperty
   a_unm: assert property (p_unm) else $error("unmapped taken");
   property p_one;
      !(tech_100_en && tech_10_en);
   endproperty
   a_one: assert property (p_one) else $error("two technologies");
   property p_neg;
      flp_tx_en |-> !tech_100_en && !tech_10_en;
   endproperty
   a_neg: assert property (p_neg) else $error("tech during bursts");
   property p_flt;
      line_sense.local_fault [*6] |-> tx_remote_fault;
   endproperty
   a_flt: assert property (p_flt) else $error("fault not sent");
   property p_rst;
      disable iff (1'b0) !presetn |=> !pready && !tech_10_en && !tech_100_en;
   endproperty
   a_rst: assert property (p_rst) else $error("busy in reset");
   property p_rate;
      pready && !pwrite && paddr == 8'h44 && tech_100_en |-> prdata[DSR_RATE];
   endproperty
   a_rate: assert property (p_rate) else $error("rate bit low");
endmodule : anm_monitor_properties

bind anm_monitor anm_monitor_properties u_props (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .prdata, .pready, .pslverr, .line_sense, .flp_tx_en,
   .tech_100_en, .tech_10_en, .tx_remote_fault);

// ---- tb/anm_monitor_tb.sv ----
// Self-checking bench of the negotiation monitor
// Assumes anm_partner on the line and the bound checker
`timescale 1ns/1ps
module anm_monitor_tb
   import anm_pkg::*;
;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, fault = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [2:0]  mode = 3'h0;
   logic [3:0]  lag = 4'h0;
   logic [15:0] word = 16'h0000, pword;
   logic [31:0] pwdata = 32'h0000_0000, prdata, note;
   logic        pready, pslverr, flp_tx_en, tech_100_en, tech_10_en, full_duplex, tx_rf;
   anm_sense_t  sense;
   logic [31:0] q[$];
   int          fails = 0, checks = 0;

   initial begin
      forever #10 pclk = ~pclk;
   end
   anm_monitor DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .line_sense(sense), .partner_word(pword), .flp_tx_en,
      .tech_100_en, .tech_10_en, .full_duplex, .tx_remote_fault(tx_rf));
   anm_partner u_far (.pclk, .mode, .lag, .fault, .word, .flp_tx_en, .line_sense(sense),
      .partner_word(pword));

   // ====================
   // Tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error %0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk
   task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d,
                      input logic [15:0] m = 16'hFFFF);
      if (!w) begin
         q.push_back({m, d});
      end
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {16'h0000, w ? d : 16'h0000};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : acc
   task automatic hold(input int n);
      repeat (n) @(posedge pclk);
   endtask : hold
   task automatic complete_run();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run

   // Read data against oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         note = q.pop_front();
         chk(prdata & {16'hFFFF, note[31:16]}, {16'h0000, note[15:0]});
      end
   end

   initial begin
      void'($urandom(29));
      hold(6);
      presetn <= 1'b1;
      acc(1'b0, 8'h00, 16'h1000, 16'h9200);
      acc(1'b0, 8'h10, ADV_RST);
      acc(1'b0, 8'h08, 16'h0000);
      acc(1'b0, 8'h44, 16'h0808, 16'h3818);
      acc(1'b0, 8'h44, 16'h0808, 16'h3818);
      lag  <= 4'($urandom_range(9, 0));
      mode <= 3'h1;
      wait (tech_10_en === 1'b1);
      acc(1'b0, 8'h44, 16'h3811, 16'hF819);
      acc(1'b0, 8'h44, 16'h0010, 16'h3810);
      acc(1'b0, 8'h18, 16'h0000, 16'h0011);
      acc(1'b0, 8'h14, 16'h0020, 16'h00A0);
      acc(1'b0, 8'h04, 16'h0024, 16'h0024);
      mode <= 3'h0;
      hold(20);
      acc(1'b0, 8'h44, 16'h0018, 16'h3818);
      acc(1'b0, 8'h44, 16'h0808, 16'h3818);
      mode <= 3'h2;
      wait (tech_100_en === 1'b1);
      acc(1'b0, 8'h44, 16'hB811, 16'hF819);
      acc(1'b0, 8'h14, 16'h0080, 16'h0080);
      mode <= 3'h0;
      hold(20);
      mode <= 3'h3;
      hold(20);
      acc(1'b0, 8'h18, 16'h0010, 16'h0010);
      mode <= 3'h0;
      acc(1'b1, 8'h00, 16'h1200);
      acc(1'b0, 8'h00, 16'h0000, 16'h0200);
      word <= 16'h2101 | (16'($urandom()) & 16'h00E0);
      mode <= 3'h4;
      wait (tech_100_en === 1'b1);
      @(posedge pclk);
      chk({30'h0, full_duplex, tech_10_en}, 32'h0000_0002);
      acc(1'b0, 8'h18, 16'h0001, 16'h0001);
      acc(1'b0, 8'h4C, 16'h2000, 16'h2000);
      acc(1'b0, 8'h44, 16'hC002, 16'hC002);
      fault <= 1'b1;
      hold(8);
      acc(1'b0, 8'h10, 16'h2000, 16'h2000);
      fault <= 1'b0;
      mode  <= 3'h0;
      acc(1'b1, 8'h00, 16'h8000);
      hold(10);
      acc(1'b0, 8'h44, 16'h0808, 16'h3818);
      complete_run();
   end
   initial begin
      hold(20000);
      fails++;
      complete_run();
   end
endmodule : anm_monitor_tb

// ---- tb/anm_partner.sv ----
// Link partner model driving line sense
// Assumes bench sets mode, lag and word on pclk edges
`timescale 1ns/1ps
module anm_partner
   import anm_pkg::*;
(
   // Commands
   input  wire logic        pclk,
   input  wire logic [2:0]  mode,
   input  wire logic [3:0]  lag,
   input  wire logic        fault,
   input  wire logic [15:0] word,
   input  wire logic        flp_tx_en,
   // Line side
   output anm_sense_t       line_sense,
   output logic      [15:0] partner_word
);
   logic [2:0] mode_q = 3'h0;
   logic [4:0] n_q    = 5'h00;
   // Answer timer, runs once bursts are seen
   always_ff @(posedge pclk) begin
      mode_q <= mode;
      if (mode != mode_q) begin
         n_q <= 5'h00;
      end else if ((flp_tx_en || n_q != 5'h00) && n_q != 5'h1F) begin
         n_q <= n_q + 5'h01;
      end
   end
   always_comb begin
      line_sense             = '0;
      line_sense.energy      = (mode != 3'h0);
      line_sense.link_ok     = line_sense.energy && (n_q >= {1'b0, lag});
      line_sense.nlp         = mode[0] && line_sense.link_ok;
      line_sense.idle100     = mode[1] && line_sense.link_ok;
      line_sense.flp         = mode[2] && line_sense.link_ok;
      line_sense.page_valid  = mode[2] && (n_q >= {1'b0, lag} + 5'h04);
      line_sense.local_fault = fault;
      partner_word           = line_sense.flp ? word : ~word;
   end
endmodule : anm_partner
